/* rtl/uca_pkg.sv */
// Register map, field positions and state types of the serial port
package uca_pkg;
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_CTL2 = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  localparam int C1_EN = 7;
  localparam int C1_BNO = 6;
  localparam int C1_PARITY_ENABLE = 5;
  localparam int C1_PRT = 4;
  localparam int C1_STOP_BIT_COUNT = 3;
  localparam int C1_BRK = 2;
  localparam int C1_RX9 = 1;
  localparam int C1_TX9 = 0;
  localparam int C2_TRANSMITTER_ON = 7;
  localparam int C2_RECEIVER_ON = 6;
  localparam int C2_BAUD_SPEED_SELECT = 5;
  localparam int C2_ADDRESS_DETECT_ON = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RIE = 2;
  localparam int C2_XMIT_IDLE_IRQ_ENABLE = 1;
  localparam int C2_XMIT_EMPTY_IRQ_ENABLE = 0;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] BRK_BITS = 4'hD;
  localparam logic [3:0] TX_BITS_BASE = 4'h9;
  localparam logic [3:0] RX_BITS_LAST = 4'h7;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_BRK = 2'b11
  } uca_tx_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } uca_rx_t;
endpackage : uca_pkg

/* rtl/uca_top.sv */
// Asynchronous serial port with control options, reached over APB
`timescale 1ns/1ns
module uca_top #(
  parameter int BAUD_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_i,
  input wire logic low_power_i,
  output logic tx_o,
  output logic tx_oe_o,
  output logic rx_own_o,
  output logic irq_o,
  output logic wake_o
);
  generate
    if (BAUD_W != 8) begin : g_chk
      $error("uca_top: divider must be 8 bits");
    end
  endgenerate

  function automatic logic [11:0] uca_frame(input logic [8:0] d, input logic nine,
                                            input logic pen, input logic odd);
    logic [8:0] w;
    w = d;
    if (pen) begin
      if (nine) begin
        w[8] = (^d[7:0]) ^ odd;
      end else begin
        w[7] = (^d[6:0]) ^ odd;
      end
    end
    uca_frame = nine ? {2'b11, w, 1'b0} : {3'b111, w[7:0], 1'b0};
  endfunction : uca_frame

  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic [7:0] baud_reg;
  logic pready_reg;
  logic stat_rd_reg;
  logic en;
  logic hs;
  logic tx_act;
  logic rx_act;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [7:0] rd_mux;
  assign en = ctl1_reg[uca_pkg::C1_EN];
  assign hs = ctl2_reg[uca_pkg::C2_BAUD_SPEED_SELECT];
  assign tx_act = en & ctl2_reg[uca_pkg::C2_TRANSMITTER_ON];
  assign rx_act = en & ctl2_reg[uca_pkg::C2_RECEIVER_ON];
  assign wr_en = psel_i & penable_i & pready_reg & pwrite_i;
  assign rd_en = psel_i & penable_i & pready_reg & ~pwrite_i;
  assign hit = (paddr_i == uca_pkg::OFF_STAT) | (paddr_i == uca_pkg::OFF_CTL1) |
               (paddr_i == uca_pkg::OFF_CTL2) | (paddr_i == uca_pkg::OFF_DATA) |
               (paddr_i == uca_pkg::OFF_BAUD);

  // Status and data flags
  logic xmit_empty_flag_reg;
  logic xmit_quiet_flag_reg;
  logic recv_quiet_flag_reg;
  logic recv_available_flag_reg;
  logic overrun_error_reg;
  logic framing_error_reg;
  logic parity_error_reg;
  logic nf_reg;
  logic rx9_reg;
  logic [7:0] rx_data_reg;

  // Control registers; a disabled port forces its transmitter and receiver enables and break off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl1_reg <= uca_pkg::CTL1_RST;
      ctl2_reg <= uca_pkg::CTL2_RST;
      baud_reg <= uca_pkg::BAUD_RST;
    end else begin
      if (wr_en && paddr_i == uca_pkg::OFF_CTL1) begin
        ctl1_reg <= pwdata_i[7:0];
      end
      if (wr_en && paddr_i == uca_pkg::OFF_CTL2) begin
        ctl2_reg <= pwdata_i[7:0];
      end
      if (wr_en && paddr_i == uca_pkg::OFF_BAUD) begin
        baud_reg <= pwdata_i[7:0];
      end
      if (!en) begin
        ctl1_reg[uca_pkg::C1_BRK] <= 1'b0;
        ctl2_reg[uca_pkg::C2_TRANSMITTER_ON] <= 1'b0;
        ctl2_reg[uca_pkg::C2_RECEIVER_ON] <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (paddr_i)
      uca_pkg::OFF_STAT: rd_mux = {parity_error_reg, nf_reg, framing_error_reg, overrun_error_reg,
                                   recv_quiet_flag_reg, recv_available_flag_reg, xmit_quiet_flag_reg, xmit_empty_flag_reg};
      uca_pkg::OFF_CTL1: rd_mux = {ctl1_reg[7:2], rx9_reg, 1'b0};
      uca_pkg::OFF_CTL2: rd_mux = ctl2_reg;
      uca_pkg::OFF_DATA: rd_mux = rx_data_reg;
      uca_pkg::OFF_BAUD: rd_mux = baud_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_reg <= psel_i & penable_i & ~pready_reg;
      if (psel_i && penable_i && !pready_reg) begin
        prdata_o <= {24'h00_0000, pwrite_i ? 8'h00 : rd_mux};
        pslverr_o <= ~hit;
      end else begin
        prdata_o <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
    end
  end
  assign pready_o = pready_reg;

  // Baud generator: 16x oversampling tick, extra divide by 4 in low speed
  logic [7:0] bcnt_reg;
  logic [1:0] pre_reg;
  logic tick;
  assign tick = en & (bcnt_reg == 8'h00) & (hs | pre_reg == 2'h3);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt_reg <= 8'h00;
      pre_reg <= 2'h0;
    end else if (!en) begin
      bcnt_reg <= 8'h00;
      pre_reg <= 2'h0;
    end else if (bcnt_reg == 8'h00) begin
      bcnt_reg <= baud_reg;
      pre_reg <= pre_reg + 2'h1;
    end else begin
      bcnt_reg <= bcnt_reg - 8'h01;
    end
  end

  // Transmit buffer and shifter
  uca_pkg::uca_tx_t tx_state_reg;
  logic [8:0] tx_buf_reg;
  logic tx_full_reg;
  logic [3:0] tx_sub_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [3:0] brk_cnt_reg;
  logic tx_line_reg;
  logic bit_tick;
  logic tx_load;
  logic data_wr;
  logic [11:0] tx_frame;
  // Frame built outside the process; a function result cannot be part-selected
  assign tx_frame = uca_frame(tx_buf_reg, ctl1_reg[uca_pkg::C1_BNO], ctl1_reg[uca_pkg::C1_PARITY_ENABLE],
                              ctl1_reg[uca_pkg::C1_PRT]);
  assign bit_tick = tick & (tx_sub_reg == uca_pkg::SUB_LAST);
  assign tx_load = tx_act & bit_tick & (tx_state_reg == uca_pkg::TX_IDLE) & tx_full_reg;
  assign data_wr = wr_en & (paddr_i == uca_pkg::OFF_DATA);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_full_reg <= 1'b0;
      tx_buf_reg <= 9'h000;
    end else if (!tx_act) begin
      tx_full_reg <= 1'b0;
    end else if (data_wr) begin
      tx_full_reg <= 1'b1;
      tx_buf_reg <= {ctl1_reg[uca_pkg::C1_TX9], pwdata_i[7:0]};
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sub_reg <= 4'h0;
    end else if (!tx_act) begin
      tx_sub_reg <= 4'h0;
    end else if (tick) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_reg <= uca_pkg::TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      brk_cnt_reg <= 4'h0;
      tx_line_reg <= 1'b1;
    end else if (!tx_act) begin
      tx_state_reg <= uca_pkg::TX_IDLE;
      tx_line_reg <= 1'b1;
      tx_left_reg <= 4'h0;
    end else if (bit_tick) begin
      case (tx_state_reg)
        uca_pkg::TX_IDLE: begin
          if (tx_full_reg) begin
            tx_state_reg <= uca_pkg::TX_SHIFT;
            tx_line_reg <= 1'b0;
            tx_sh_reg <= tx_frame[11:1];
            tx_left_reg <= uca_pkg::TX_BITS_BASE + {3'h0, ctl1_reg[uca_pkg::C1_BNO]} +
                           {3'h0, ctl1_reg[uca_pkg::C1_STOP_BIT_COUNT]};
          end else if (ctl1_reg[uca_pkg::C1_BRK]) begin
            tx_state_reg <= uca_pkg::TX_BRK;
            tx_line_reg <= 1'b0;
            brk_cnt_reg <= 4'h0;
          end
        end
        uca_pkg::TX_SHIFT: begin
          if (tx_left_reg == 4'h0) begin
            tx_state_reg <= uca_pkg::TX_IDLE;
            tx_line_reg <= 1'b1;
          end else begin
            tx_line_reg <= tx_sh_reg[0];
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
          end
        end
        uca_pkg::TX_BRK: begin
          if (brk_cnt_reg != uca_pkg::BRK_BITS) begin
            brk_cnt_reg <= brk_cnt_reg + 4'h1;
          end else if (!ctl1_reg[uca_pkg::C1_BRK]) begin
            tx_state_reg <= uca_pkg::TX_IDLE;
            tx_line_reg <= 1'b1;
          end
        end
        default: begin
          tx_state_reg <= uca_pkg::TX_IDLE;
          tx_line_reg <= 1'b1;
        end
      endcase
    end
  end

  // Receiver: majority of three samples around the bit centre
  uca_pkg::uca_rx_t rx_state_reg;
  logic [3:0] rx_sub_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_cnt_reg;
  logic s_a_reg;
  logic s_b_reg;
  logic nz_acc_reg;
  logic rx_bit;
  logic rx_noisy;
  logic at_c;
  logic rx_done;
  logic nine;
  logic [8:0] rx_word;
  logic abit;
  logic drop;
  assign nine = ctl1_reg[uca_pkg::C1_BNO];
  assign rx_bit = (s_a_reg & s_b_reg) | (s_a_reg & rx_i) | (s_b_reg & rx_i);
  assign rx_noisy = (s_a_reg != s_b_reg) | (s_b_reg != rx_i);
  assign at_c = tick & (rx_sub_reg == uca_pkg::SAMPLE_C);
  assign rx_done = rx_act & at_c & (rx_state_reg == uca_pkg::RX_STOP);
  assign rx_word = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
  assign abit = nine ? rx_word[8] : rx_word[7];
  assign drop = ctl2_reg[uca_pkg::C2_ADDRESS_DETECT_ON] & ~abit;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_reg <= uca_pkg::RX_IDLE;
      rx_sub_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_cnt_reg <= 4'h0;
      s_a_reg <= 1'b1;
      s_b_reg <= 1'b1;
      nz_acc_reg <= 1'b0;
    end else if (!rx_act) begin
      rx_state_reg <= uca_pkg::RX_IDLE;
      rx_sub_reg <= 4'h0;
    end else if (tick) begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
      if (rx_sub_reg == uca_pkg::SAMPLE_A) begin
        s_a_reg <= rx_i;
      end
      if (rx_sub_reg == uca_pkg::SAMPLE_B) begin
        s_b_reg <= rx_i;
      end
      case (rx_state_reg)
        uca_pkg::RX_IDLE: begin
          if (!rx_i) begin
            rx_state_reg <= uca_pkg::RX_START;
            rx_sub_reg <= 4'h0;
            nz_acc_reg <= 1'b0;
          end
        end
        uca_pkg::RX_START: begin
          if (at_c) begin
            rx_state_reg <= rx_bit ? uca_pkg::RX_IDLE : uca_pkg::RX_DATA;
            rx_cnt_reg <= 4'h0;
            nz_acc_reg <= rx_noisy;
          end
        end
        uca_pkg::RX_DATA: begin
          if (at_c) begin
            rx_sh_reg <= {rx_bit, rx_sh_reg[8:1]};
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            nz_acc_reg <= nz_acc_reg | rx_noisy;
            if (rx_cnt_reg == uca_pkg::RX_BITS_LAST + {3'h0, nine}) begin
              rx_state_reg <= uca_pkg::RX_STOP;
            end
          end
        end
        uca_pkg::RX_STOP: begin
          if (at_c) begin
            rx_state_reg <= uca_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= uca_pkg::RX_IDLE;
      endcase
    end
  end

  // Flags: a hardware set wins over the software clear sequence
  logic data_rd;
  logic seq_clr;
  assign data_rd = rd_en & (paddr_i == uca_pkg::OFF_DATA);
  assign seq_clr = stat_rd_reg & (data_rd | data_wr);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_rd_reg <= 1'b0;
    end else if (rd_en && paddr_i == uca_pkg::OFF_STAT) begin
      stat_rd_reg <= 1'b1;
    end else if (data_rd || data_wr) begin
      stat_rd_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      recv_available_flag_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
      framing_error_reg <= 1'b0;
      parity_error_reg <= 1'b0;
      nf_reg <= 1'b0;
      rx9_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (!rx_act) begin
      recv_available_flag_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
      framing_error_reg <= 1'b0;
      parity_error_reg <= 1'b0;
      nf_reg <= 1'b0;
    end else if (rx_done && !drop) begin
      if (recv_available_flag_reg && !seq_clr) begin
        overrun_error_reg <= 1'b1;
      end else begin
        recv_available_flag_reg <= 1'b1;
        rx_data_reg <= rx_word[7:0];
        rx9_reg <= rx_word[8];
        framing_error_reg <= ~rx_bit;
        parity_error_reg <= ctl1_reg[uca_pkg::C1_PARITY_ENABLE] & ((^rx_word) ^ ctl1_reg[uca_pkg::C1_PRT]);
        nf_reg <= nz_acc_reg | rx_noisy;
        overrun_error_reg <= 1'b0;
      end
    end else if (seq_clr && data_rd) begin
      recv_available_flag_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
      framing_error_reg <= 1'b0;
      parity_error_reg <= 1'b0;
      nf_reg <= 1'b0;
    end
  end

  // Transmit status follows the buffer and shifter, receive idle follows the receiver, one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xmit_empty_flag_reg <= 1'b1;
      xmit_quiet_flag_reg <= 1'b1;
      recv_quiet_flag_reg <= 1'b1;
    end else begin
      xmit_empty_flag_reg <= ~tx_full_reg;
      xmit_quiet_flag_reg <= ~tx_full_reg & (tx_state_reg == uca_pkg::TX_IDLE) &
                   ~(tx_act & ctl1_reg[uca_pkg::C1_BRK]);
      recv_quiet_flag_reg <= ~rx_act | (rx_state_reg == uca_pkg::RX_IDLE);
    end
  end

  // Pins, request and wake-up, all registered
  logic rx_prev_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
      tx_oe_o <= 1'b0;
      rx_own_o <= 1'b0;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else begin
      tx_o <= ~tx_act | tx_line_reg;
      tx_oe_o <= tx_act;
      rx_own_o <= rx_act;
      irq_o <= (ctl2_reg[uca_pkg::C2_RIE] & (recv_available_flag_reg | overrun_error_reg)) |
               (ctl2_reg[uca_pkg::C2_XMIT_IDLE_IRQ_ENABLE] & xmit_quiet_flag_reg) |
               (ctl2_reg[uca_pkg::C2_XMIT_EMPTY_IRQ_ENABLE] & xmit_empty_flag_reg);
      rx_prev_reg <= rx_i;
      wake_o <= ctl2_reg[uca_pkg::C2_WAKE] & low_power_i & rx_prev_reg & ~rx_i;
    end
  end

  sequence s_lo_run;
    (!hs && en && baud_reg == 8'h00) [*4];
  endsequence
  property p_pins_free;
    @(posedge clk_i) disable iff (rst_i) !en |=> !tx_oe_o && !rx_own_o;
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("pins not released");
  property p_dis_flags;
    @(posedge clk_i) disable iff (rst_i) !en [*3] |-> xmit_empty_flag_reg && xmit_quiet_flag_reg && recv_quiet_flag_reg && !recv_available_flag_reg && !overrun_error_reg;
  endproperty
  a_dis_flags: assert property (p_dis_flags) else $error("disable flags wrong");
  property p_dis_ctl;
    @(posedge clk_i) disable iff (rst_i)
      !en |=> !ctl2_reg[uca_pkg::C2_TRANSMITTER_ON] && !ctl2_reg[uca_pkg::C2_RECEIVER_ON] && !ctl1_reg[uca_pkg::C1_BRK];
  endproperty
  a_dis_ctl: assert property (p_dis_ctl) else $error("enables not cleared");
  property p_tx_off;
    @(posedge clk_i) disable iff (rst_i) !tx_act |=> tx_o && !tx_oe_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx not released");
  property p_brk_hold;
    @(posedge clk_i) disable iff (rst_i)
      tx_state_reg == uca_pkg::TX_BRK && brk_cnt_reg != uca_pkg::BRK_BITS && tx_act |=>
      tx_state_reg == uca_pkg::TX_BRK && !tx_line_reg;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break too short");
  property p_addr;
    @(posedge clk_i) disable iff (rst_i)
      $rose(recv_available_flag_reg) && $past(ctl2_reg[uca_pkg::C2_ADDRESS_DETECT_ON]) |->
      ($past(ctl1_reg[uca_pkg::C1_BNO]) ? rx9_reg : rx_data_reg[7]);
  endproperty
  a_addr: assert property (p_addr) else $error("data word delivered");
  property p_irq_rx;
    @(posedge clk_i) disable iff (rst_i) ctl2_reg[uca_pkg::C2_RIE] && recv_available_flag_reg |=> irq_o;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("receive request missing");
  property p_irq_off;
    @(posedge clk_i) disable iff (rst_i) ctl2_reg[2:0] == 3'h0 |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while masked");
  // Low speed with divider 0: one tick in every four clocks
  property p_baud_lo;
    @(posedge clk_i) disable iff (rst_i)
      tick && !hs && baud_reg == 8'h00 ##1 s_lo_run |->
      tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3);
  endproperty
  a_baud_lo: assert property (p_baud_lo) else $error("low speed tick spacing wrong");
  // Only while the settings still hold in the following cycle
  property p_baud_hi;
    @(posedge clk_i) disable iff (rst_i)
      tick && hs && baud_reg == 8'h00 ##1 (hs && en && baud_reg == 8'h00) |-> tick;
  endproperty
  a_baud_hi: assert property (p_baud_hi) else $error("high speed tick late");
  property p_wake;
    @(posedge clk_i) disable iff (rst_i) !ctl2_reg[uca_pkg::C2_WAKE] |=> !wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without enable");
endmodule : uca_top

/* testbench/uca_peer.sv */
// Remote serial peer: drives frames on RX, captures frames from TX
`timescale 1ns/1ns
module uca_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  // Line idles high, as a pulled-up line would
  initial rx_o = 1'b1;
  task automatic send(input logic [8:0] data, input int nbits);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      rx_o <= data[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_i);
  endtask : send
  // Samples mid-bit, so a wrong bit period shows as wrong bits
  task automatic grab(input int nbits, output logic [10:0] bits, output logic ok);
    int k;
    bits = 11'h000;
    k = 0;
    while (tx_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    ok = (k < 4000);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      bits[i] = tx_i;
    end
  endtask : grab
endmodule : uca_peer

/* testbench/uca_top_tb.sv */
// Self-checking bench for the serial port control options
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uca_top_tb;
  localparam logic [7:0] ST = uca_pkg::OFF_STAT;
  localparam logic [7:0] C1 = uca_pkg::OFF_CTL1;
  localparam logic [7:0] C2 = uca_pkg::OFF_CTL2;
  localparam logic [7:0] DT = uca_pkg::OFF_DATA;
  localparam logic [7:0] BD = uca_pkg::OFF_BAUD;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic low_power_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx_i, tx_o, tx_oe_o, rx_own_o, irq_o, wake_o;
  logic [31:0] rd;
  logic serr, ok;
  logic [10:0] got;
  int n_errors = 0;
  int n_tests = 0;
  int n_wake = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake_o === 1'b1) n_wake++;
  uca_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rx_i(rx_i), .low_power_i(low_power_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .rx_own_o(rx_own_o),
    .irq_o(irq_o), .wake_o(wake_o));
  uca_peer #(.BIT_CLKS(16)) peer (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    rd = prdata_o;
    serr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      n_errors++;
      $display("[FAIL] %0t no ready", $time);
      conclude();
    end
  endtask : apb
  task automatic t_reset();
    apb(0, ST, 8'h00); `CHK(rd, 32'h0000_000B)
    apb(0, C1, 8'h00); `CHK(rd, 32'h0000_0000)
    apb(0, C2, 8'h00); `CHK(rd, 32'h0000_0000)
    apb(0, 8'h14, 8'h00); `CHK(serr, 1'b1)
    // Unit enables are refused while the port is off
    apb(1, C2, 8'hC0);
    apb(0, C2, 8'h00); `CHK(rd, 32'h0000_0000)
    `CHK(tx_oe_o, 1'b0)
    `CHK(rx_own_o, 1'b0)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_tx();
    logic [7:0] cfg [4] = '{8'h80, 8'hA8, 8'hB0, 8'hC1};
    logic [7:0] dat [4] = '{8'hA5, 8'h37, 8'h37, 8'h5A};
    logic [10:0] ex;
    logic [8:0] w;
    logic p;
    int nd, ns;
    apb(1, BD, 8'h00);
    apb(1, C1, 8'h80);
    apb(1, C2, 8'hA0);
    // Pin enable is registered one cycle behind the write
    repeat (2) @(posedge clk_i);
    `CHK(tx_oe_o, 1'b1)
    for (int c = 0; c < 4; c++) begin
      nd = cfg[c][6] ? 9 : 8;
      ns = cfg[c][3] ? 2 : 1;
      w = {cfg[c][0], dat[c]};
      ex = 11'h000;
      p = cfg[c][4];
      for (int i = 0; i < nd - 1; i++) p ^= w[i];
      for (int i = 0; i < nd; i++) ex[i] = w[i];
      if (cfg[c][5]) ex[nd-1] = p;
      for (int i = 0; i < ns; i++) ex[nd+i] = 1'b1;
      apb(1, C1, cfg[c]);
      apb(1, DT, dat[c]);
      peer.grab(nd + ns, got, ok);
      `CHK(ok, 1'b1)
      `CHK(got, ex)
      repeat (32) @(posedge clk_i);
    end
    $display("t_tx done");
  endtask : t_tx
  task automatic t_irq();
    logic [7:0] v [3] = '{8'h81, 8'h82, 8'hA0};
    logic e [3] = '{1'b1, 1'b1, 1'b0};
    apb(1, C1, 8'h80);
    for (int i = 0; i < 3; i++) begin
      apb(1, C2, v[i]);
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, e[i])
    end
    $display("t_irq done");
  endtask : t_irq
  task automatic t_rx();
    apb(1, C2, 8'h64);
    repeat (2) @(posedge clk_i);
    `CHK(rx_own_o, 1'b1)
    peer.send(9'h03C, 8);
    `CHK(irq_o, 1'b1)
    apb(0, ST, 8'h00); `CHK(rd[2], 1'b1)
    apb(0, DT, 8'h00); `CHK(rd, 32'h0000_003C)
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    apb(1, C2, 8'h74);
    peer.send(9'h012, 8);
    `CHK(irq_o, 1'b0)
    apb(0, ST, 8'h00); `CHK(rd[2], 1'b0)
    peer.send(9'h093, 8);
    `CHK(irq_o, 1'b1)
    apb(0, ST, 8'h00);
    apb(0, DT, 8'h00); `CHK(rd, 32'h0000_0093)
    apb(1, C1, 8'hC0);
    peer.send(9'h100, 9);
    apb(0, C1, 8'h00); `CHK(rd[1], 1'b1)
    // Receiver off drops the unread word and releases RX
    apb(1, C2, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK(rx_own_o, 1'b0)
    apb(0, ST, 8'h00); `CHK(rd[3:2], 2'b10)
    $display("t_rx done");
  endtask : t_rx
  task automatic t_break();
    int k;
    int bad;
    apb(1, C1, 8'h80);
    apb(1, C2, 8'hA0);
    // Capture must already watch before the frame can start
    fork
      peer.grab(9, got, ok);
      begin
        apb(1, DT, 8'hFF);
        apb(1, C1, 8'h84);
      end
    join
    `CHK(ok, 1'b1)
    `CHK(got, 11'h1FF)
    k = 0;
    while (tx_o !== 1'b0 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    bad = 0;
    repeat (13 * 16) begin
      @(posedge clk_i);
      if (tx_o !== 1'b0) bad++;
    end
    `CHK(bad, 0)
    apb(1, C1, 8'h80);
    repeat (40) @(posedge clk_i);
    `CHK(tx_o, 1'b1)
    $display("t_break done");
  endtask : t_break
  task automatic t_disable();
    apb(1, BD, 8'h05);
    apb(1, C1, 8'hC8);
    apb(1, C2, 8'hA0);
    apb(1, DT, 8'h55);
    repeat (100) @(posedge clk_i);
    apb(1, C1, 8'h48);
    repeat (2) @(posedge clk_i);
    `CHK(tx_o, 1'b1)
    `CHK(tx_oe_o, 1'b0)
    apb(0, ST, 8'h00); `CHK(rd, 32'h0000_000B)
    apb(0, C2, 8'h00); `CHK(rd, 32'h0000_0020)
    apb(0, C1, 8'h00); `CHK(rd & 32'h0000_00FD, 32'h0000_0048)
    apb(0, BD, 8'h00); `CHK(rd, 32'h0000_0005)
    apb(1, BD, 8'h00);
    apb(1, C1, 8'h80);
    apb(1, C2, 8'hA0);
    apb(1, DT, 8'h55);
    repeat (20) @(posedge clk_i);
    apb(1, C2, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK(tx_oe_o, 1'b0)
    `CHK(tx_o, 1'b1)
    apb(0, ST, 8'h00); `CHK(rd[1:0], 2'b11)
    $display("t_disable done");
  endtask : t_disable
  task automatic t_wake();
    int n;
    apb(1, C2, 8'h08);
    low_power_i <= 1'b1;
    n = n_wake;
    peer.send(9'h000, 8);
    `CHK(n_wake - n, 1)
    apb(1, C2, 8'h00);
    n = n_wake;
    peer.send(9'h000, 8);
    `CHK(n_wake - n, 0)
    low_power_i <= 1'b0;
    $display("t_wake done");
  endtask : t_wake
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_irq();
    t_rx();
    t_break();
    t_disable();
    t_wake();
    conclude();
  end
endmodule : uca_top_tb
